/* File: core/pcls_loader.v */
// Overview of operation
// R01: Before supply is good, stay quiescent: pins, scan port off, outputs pulled up.
// R02: After supply good, initialise all user registers and become ready.
// R03: Erased device: outputs disabled with pull-up, scan port enabled.
// R04: Programmed device: pins as configured, scan port stays enabled.
// R05: Inputs, clocks, logic blocks enabled only in valid user operation.
// R06: Loading starts only once the supply-good indication is seen.
// R07: Loading is stepped by a state machine on the on-chip clock.
// R08: Full load lasts about 100 us, a parameterised cycle count.
// R09: All configuration latches are cleared before any bit is loaded.
// R10: Step every address, strobe its latches, then enable the pins.
// R11: Four security combinations from read-protect and write-protect bits.
// R12: Read protection refuses readback of the stored pattern.
// R13: Read protection refuses programming but still allows erase.
// R14: Only a full erase clears read protection.
// R15: Write protection blocks erase and program until an unlock sequence.
// R16: Decode the standard scan instructions plus private programming ones.
// R17: Outside valid user operation pin hold acts as pull-up.
// R18: During in-system programming all user pins are high impedance, pulled up.
// R19: Synchronise supply good; a done flag gates entry to user operation.
// R20: Erase clears both protections and leaves the device erased.
`timescale 1ns/1ps
`include "pcls_consts.vh"
`default_nettype none

module pcls_loader #(
   parameter LOAD_CYCLES = `PCLS_LOAD_CYCLES,
   parameter NUM_ADDR = `PCLS_NUM_ADDR,
   parameter ADDR_W = `PCLS_ADDR_W,
   parameter DATA_W = `PCLS_DATA_W
)(
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire core_supply_good,
   input wire [DATA_W-1:0] nv_data,
   input wire nv_programmed,
   input wire nv_read_prot,
   input wire nv_write_prot,
   input wire [`PCLS_IR_W-1:0] scan_instr,
   input wire scan_instr_update,
   input wire req_valid,
   input wire [`PCLS_OP_W-1:0] req_op,
   output reg [ADDR_W-1:0] nv_addr_r,
   output reg nv_rd_en_r,
   output reg latch_clear_r,
   output reg latch_strobe_r,
   output reg [ADDR_W-1:0] latch_addr_r,
   output reg [DATA_W-1:0] latch_data_r,
   output reg cfg_done_r,
   output reg user_regs_init_r,
   output reg scan_port_en_r,
   output reg pin_out_en_r,
   output reg pin_pullup_r,
   output reg pin_bus_hold_r,
   output reg pin_in_en_r,
   output reg logic_en_r,
   output reg in_system_programming_r,
   output reg internal_test_mode_r,
   output reg [`PCLS_CL_W-1:0] instr_class_r,
   output reg read_prot_r,
   output reg write_prot_r,
   output reg programmed_r,
   output reg op_grant_r,
   output reg op_refuse_r,
   output reg [`PCLS_OP_W-1:0] op_code_r
);

   localparam [3:0] S_OFF = 4'h1;
   localparam [3:0] S_CLR = 4'h2;
   localparam [3:0] S_LOAD = 4'h4;
   localparam [3:0] S_DONE = 4'h8;
   localparam STEP_CYCLES = (LOAD_CYCLES / NUM_ADDR) < 2 ? 2 : (LOAD_CYCLES / NUM_ADDR);
   localparam [ADDR_W-1:0] LAST_ADDR = NUM_ADDR[ADDR_W-1:0] - 1'b1;
   localparam [31:0] LAST_STEP = STEP_CYCLES - 1;

   function [`PCLS_CL_W-1:0] pcls_decode;
      input [`PCLS_IR_W-1:0] ir;
      begin
         case (ir)
            `PCLS_IR_EXTEST: pcls_decode = `PCLS_CL_EXTEST;
            `PCLS_IR_SAMPLE: pcls_decode = `PCLS_CL_SAMPLE;
            `PCLS_IR_INTERNAL_TEST_MODE: pcls_decode = `PCLS_CL_INTERNAL_TEST_MODE;
            `PCLS_IR_USERCODE: pcls_decode = `PCLS_CL_USERCODE;
            `PCLS_IR_IDCODE: pcls_decode = `PCLS_CL_IDCODE;
            `PCLS_IR_HIGHZ: pcls_decode = `PCLS_CL_HIGHZ;
            `PCLS_IR_CLAMP: pcls_decode = `PCLS_CL_CLAMP;
            `PCLS_IR_ISP_ENTER: pcls_decode = `PCLS_CL_ISP_ENTER;
            `PCLS_IR_ISP_EXIT: pcls_decode = `PCLS_CL_ISP_EXIT;
            `PCLS_IR_UNLOCK_A: pcls_decode = `PCLS_CL_UNLOCK_A;
            `PCLS_IR_UNLOCK_B: pcls_decode = `PCLS_CL_UNLOCK_B;
            default: pcls_decode = `PCLS_CL_BYPASS;
         endcase
      end
   endfunction

   reg supply_meta_r;
   reg supply_sync_r;
   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg [31:0] step_r;
   reg unlock_armed_r;
   wire step_end;
   wire user_mode;
   wire [`PCLS_CL_W-1:0] dec_class;

   assign step_end = (step_r == LAST_STEP);
   assign dec_class = pcls_decode(scan_instr); // R16
   // Valid user operation needs a finished load of a programmed pattern
   assign user_mode = cfg_done_r & programmed_r & ~in_system_programming_r
      & ~internal_test_mode_r; // R05 R19

   // Two-stage supply sync
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         supply_meta_r <= 1'b0;
         supply_sync_r <= 1'b0;
      end
      else if (ce)
      begin
         supply_meta_r <= core_supply_good;
         supply_sync_r <= supply_meta_r; // R19
      end
   end

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         S_OFF:
            if (supply_sync_r)
               state_nxt = S_CLR; // R06
         S_CLR:
            state_nxt = S_LOAD; // R09
         S_LOAD:
            if (step_end && nv_addr_r == LAST_ADDR)
               state_nxt = S_DONE; // R10
         S_DONE:
            state_nxt = S_DONE;
         default:
            state_nxt = S_OFF;
      endcase
      if (!supply_sync_r)
         state_nxt = S_OFF; // R01
   end

   // Load sequencer on the on-chip clock
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r <= S_OFF;
         step_r <= 32'h0;
         nv_addr_r <= {ADDR_W{1'b0}};
         nv_rd_en_r <= 1'b0;
         latch_clear_r <= 1'b0;
         latch_strobe_r <= 1'b0;
         latch_addr_r <= {ADDR_W{1'b0}};
         latch_data_r <= {DATA_W{1'b0}};
         cfg_done_r <= 1'b0;
         user_regs_init_r <= 1'b0;
      end
      else if (ce)
      begin
         state_r <= state_nxt; // R07
         latch_clear_r <= 1'b0;
         latch_strobe_r <= 1'b0;
         case (state_r)
            S_OFF:
            begin
               step_r <= 32'h0;
               nv_addr_r <= {ADDR_W{1'b0}};
               nv_rd_en_r <= 1'b0;
               cfg_done_r <= 1'b0;
               user_regs_init_r <= 1'b0;
               if (state_nxt == S_CLR)
                  latch_clear_r <= 1'b1; // R09
            end
            S_CLR:
            begin
               nv_rd_en_r <= 1'b1;
               step_r <= 32'h0;
            end
            S_LOAD:
            begin
               if (step_end)
               begin
                  // Strobe the word for this address into its latches
                  latch_strobe_r <= 1'b1; // R10
                  latch_addr_r <= nv_addr_r;
                  latch_data_r <= nv_data;
                  step_r <= 32'h0;
                  if (nv_addr_r == LAST_ADDR)
                     nv_rd_en_r <= 1'b0;
                  else
                     nv_addr_r <= nv_addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
               end
               else
                  step_r <= step_r + 32'h1; // R08
            end
            S_DONE:
            begin
               cfg_done_r <= 1'b1; // R02 R19
               user_regs_init_r <= 1'b1; // R02
            end
            default:
               step_r <= 32'h0;
         endcase
         if (!supply_sync_r)
         begin
            cfg_done_r <= 1'b0; // R01
            user_regs_init_r <= 1'b0;
            nv_rd_en_r <= 1'b0;
         end
      end
   end

   // Scan instruction decode, programming mode and security state
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         instr_class_r <= `PCLS_CL_BYPASS;
         in_system_programming_r <= 1'b0;
         internal_test_mode_r <= 1'b0;
         unlock_armed_r <= 1'b0;
         read_prot_r <= 1'b0;
         write_prot_r <= 1'b0;
         programmed_r <= 1'b0;
         op_grant_r <= 1'b0;
         op_refuse_r <= 1'b0;
         op_code_r <= `PCLS_OP_READ;
      end
      else if (ce)
      begin
         op_grant_r <= 1'b0;
         op_refuse_r <= 1'b0;
         if (state_r == S_CLR)
         begin
            // Protection and pattern state come from the array
            programmed_r <= nv_programmed;
            read_prot_r <= nv_read_prot; // R11
            write_prot_r <= nv_write_prot; // R11
         end
         if (!cfg_done_r)
         begin
            // Scan port disabled while quiescent
            instr_class_r <= `PCLS_CL_BYPASS; // R01
            in_system_programming_r <= 1'b0;
            internal_test_mode_r <= 1'b0;
            unlock_armed_r <= 1'b0;
         end
         else
         begin
            if (scan_instr_update)
            begin
               instr_class_r <= dec_class; // R16
               internal_test_mode_r <= (dec_class == `PCLS_CL_INTERNAL_TEST_MODE); // R17
               if (dec_class == `PCLS_CL_ISP_ENTER)
                  in_system_programming_r <= 1'b1; // R18
               else if (dec_class == `PCLS_CL_ISP_EXIT)
                  in_system_programming_r <= 1'b0;
               // Two consecutive private instructions release write protection
               unlock_armed_r <= (dec_class == `PCLS_CL_UNLOCK_A); // R15
               if (dec_class == `PCLS_CL_UNLOCK_B && unlock_armed_r)
                  write_prot_r <= 1'b0; // R15
            end
            if (req_valid)
            begin
               op_code_r <= req_op;
               case (req_op)
                  `PCLS_OP_READ:
                  begin
                     op_grant_r <= in_system_programming_r & ~read_prot_r; // R12
                     op_refuse_r <= ~in_system_programming_r | read_prot_r; // R12
                  end
                  `PCLS_OP_ERASE:
                  begin
                     // Read protection does not block erase
                     op_grant_r <= in_system_programming_r & ~write_prot_r; // R13 R15
                     op_refuse_r <= ~in_system_programming_r | write_prot_r; // R15
                     if (in_system_programming_r && !write_prot_r)
                     begin
                        read_prot_r <= 1'b0; // R14 R20
                        write_prot_r <= 1'b0; // R20
                        programmed_r <= 1'b0; // R20
                     end
                  end
                  `PCLS_OP_PROGRAM,
                  `PCLS_OP_SET_RP,
                  `PCLS_OP_SET_WP:
                  begin
                     op_grant_r <= in_system_programming_r & ~read_prot_r
                        & ~write_prot_r; // R13 R15
                     op_refuse_r <= ~in_system_programming_r | read_prot_r
                        | write_prot_r; // R13 R15
                     if (in_system_programming_r && !read_prot_r && !write_prot_r)
                     begin
                        if (req_op == `PCLS_OP_PROGRAM)
                           programmed_r <= 1'b1;
                        else if (req_op == `PCLS_OP_SET_RP)
                           read_prot_r <= 1'b1; // R11
                        else
                           write_prot_r <= 1'b1; // R11
                     end
                  end
                  default:
                     op_refuse_r <= 1'b1;
               endcase
            end
         end
      end
   end

   // Pin and block enables by operating mode
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         scan_port_en_r <= 1'b0;
         pin_out_en_r <= 1'b0;
         pin_pullup_r <= 1'b1;
         pin_bus_hold_r <= 1'b0;
         pin_in_en_r <= 1'b0;
         logic_en_r <= 1'b0;
      end
      else if (ce)
      begin
         scan_port_en_r <= cfg_done_r; // R01 R03 R04
         pin_out_en_r <= user_mode; // R03 R04 R18
         pin_pullup_r <= ~user_mode; // R17 R18
         pin_bus_hold_r <= user_mode; // R17
         pin_in_en_r <= user_mode; // R05
         logic_en_r <= user_mode; // R05
      end
   end

endmodule // pcls_loader

`default_nettype wire

/* File: pkg/pcls_consts.vh */
`ifndef PCLS_CONSTS_VH
`define PCLS_CONSTS_VH

// Timing of the load sequence
`define PCLS_CLK_PERIOD_PS 5000
`define PCLS_LOAD_TIME_US 100
`define PCLS_LOAD_CYCLES ((`PCLS_LOAD_TIME_US * 1000000) / `PCLS_CLK_PERIOD_PS)
`define PCLS_NUM_ADDR 200
`define PCLS_ADDR_W 8
`define PCLS_DATA_W 32

// Operations requested over the scan port
`define PCLS_OP_W 3
`define PCLS_OP_READ 3'h0
`define PCLS_OP_PROGRAM 3'h1
`define PCLS_OP_ERASE 3'h2
`define PCLS_OP_SET_RP 3'h3
`define PCLS_OP_SET_WP 3'h4

// Instruction register codes (values arbitrary)
`define PCLS_IR_W 8
`define PCLS_IR_EXTEST 8'h00
`define PCLS_IR_SAMPLE 8'h01
`define PCLS_IR_INTERNAL_TEST_MODE 8'h02
`define PCLS_IR_USERCODE 8'hFD
`define PCLS_IR_IDCODE 8'hFE
`define PCLS_IR_HIGHZ 8'hFC
`define PCLS_IR_CLAMP 8'hFA
`define PCLS_IR_BYPASS 8'hFF
`define PCLS_IR_ISP_ENTER 8'hE8
`define PCLS_IR_ISP_EXIT 8'hF0
`define PCLS_IR_UNLOCK_A 8'hE5
`define PCLS_IR_UNLOCK_B 8'hE6

// Decoded instruction classes
`define PCLS_CL_W 4
`define PCLS_CL_BYPASS 4'h0
`define PCLS_CL_EXTEST 4'h1
`define PCLS_CL_SAMPLE 4'h2
`define PCLS_CL_USERCODE 4'h3
`define PCLS_CL_INTERNAL_TEST_MODE 4'h4
`define PCLS_CL_IDCODE 4'h5
`define PCLS_CL_HIGHZ 4'h6
`define PCLS_CL_CLAMP 4'h7
`define PCLS_CL_ISP_ENTER 4'h8
`define PCLS_CL_ISP_EXIT 4'h9
`define PCLS_CL_UNLOCK_A 4'hA
`define PCLS_CL_UNLOCK_B 4'hB

`endif

/* File: verification/pcls_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcls_consts.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD %0t mismatch", $time); end end
module pcls_loader_bench;
   localparam LC = 40;
   localparam NA = 8;
   logic clk = 0, rst_n = 0, ce = 1, core_supply_good = 0, nv_programmed = 0;
   logic nv_read_prot = 0, nv_write_prot = 0, scan_instr_update = 0, req_valid = 0;
   logic [7:0] scan_instr = 8'h00, nv_addr_r, latch_addr_r, n = 8'h00;
   logic [2:0] req_op = 3'h0, op_code_r;
   logic [31:0] nv_data, latch_data_r, key = 32'h0;
   logic [3:0] instr_class_r;
   logic nv_rd_en_r, latch_clear_r, latch_strobe_r, cfg_done_r, user_regs_init_r, scan_port_en_r;
   logic pin_out_en_r, pin_pullup_r, pin_bus_hold_r, pin_in_en_r, logic_en_r, read_prot_r;
   logic in_system_programming_r, internal_test_mode_r, write_prot_r, programmed_r;
   logic op_grant_r, op_refuse_r;
   logic [3:0] q[$];
   int num_errors = 0, checks_done = 0, t;
   logic [7:0] ic [8] = '{`PCLS_IR_EXTEST, `PCLS_IR_SAMPLE, `PCLS_IR_USERCODE, `PCLS_IR_IDCODE,
      `PCLS_IR_HIGHZ, `PCLS_IR_CLAMP, `PCLS_IR_INTERNAL_TEST_MODE, `PCLS_IR_BYPASS};
   logic [3:0] cc [8] = '{`PCLS_CL_EXTEST, `PCLS_CL_SAMPLE, `PCLS_CL_USERCODE, `PCLS_CL_IDCODE,
      `PCLS_CL_HIGHZ, `PCLS_CL_CLAMP, `PCLS_CL_INTERNAL_TEST_MODE, `PCLS_CL_BYPASS};
   always #2.5 clk = ~clk;
   pcls_loader #(.LOAD_CYCLES(LC), .NUM_ADDR(NA)) dut (.clk, .rst_n, .ce, .core_supply_good,
      .nv_data, .nv_programmed, .nv_read_prot, .nv_write_prot, .scan_instr, .scan_instr_update,
      .req_valid, .req_op, .nv_addr_r, .nv_rd_en_r, .latch_clear_r, .latch_strobe_r,
      .latch_addr_r, .latch_data_r, .cfg_done_r, .user_regs_init_r, .scan_port_en_r,
      .pin_out_en_r, .pin_pullup_r, .pin_bus_hold_r, .pin_in_en_r, .logic_en_r,
      .in_system_programming_r, .internal_test_mode_r, .instr_class_r, .read_prot_r,
      .write_prot_r, .programmed_r, .op_grant_r, .op_refuse_r, .op_code_r);
   pcls_nv_model nvm (.clk, .nv_addr(nv_addr_r), .nv_rd_en(nv_rd_en_r), .key, .nv_data);
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic req(input logic [2:0] op, input logic g);
      @(negedge clk);
      req_valid = 1;
      req_op = op;
      q.push_back({g, op});
      @(negedge clk);
      req_valid = 0;
   endtask
   task automatic ins(input logic [7:0] code);
      @(negedge clk);
      scan_instr = code;
      scan_instr_update = 1;
      @(negedge clk);
      scan_instr_update = 0;
      repeat (2) @(negedge clk);
   endtask
   // Answers are judged against the notes the request driver left, latch loads against a running address count
   always @(posedge clk)
   begin
      if (op_grant_r || op_refuse_r)
      begin
         if (q.size() == 0)
            `CHK(1'h0, 1'h1)
         else
            `CHK({op_grant_r, op_code_r}, q.pop_front())
      end
      if (latch_clear_r)
      begin
         `CHK(n == 8'h00 || n == 8'(NA), 1'h1)
         n <= 8'h00;
      end
      if (latch_strobe_r)
      begin
         `CHK({latch_addr_r, latch_data_r}, {n, key ^ {4{n}}})
         n <= n + 8'h01;
      end
   end
   initial
   begin
      #20000;
      num_errors++;
      summarize();
   end
   initial
   begin
      void'($urandom(32'h4D15A748));
      key = $urandom;
      repeat (6) @(negedge clk);
      rst_n = 1;
      repeat (4) @(negedge clk);
      `CHK({cfg_done_r, pin_pullup_r, scan_port_en_r, pin_out_en_r}, 4'h4)
      core_supply_good = 1;
      t = 0;
      while (cfg_done_r !== 1'h1 && t < 200)
      begin
         @(negedge clk);
         t++;
      end
      `CHK(t >= LC - 5 && t <= LC + 10, 1'h1)
      `CHK({n, user_regs_init_r}, {8'(NA), 1'h1})
      repeat (2) @(negedge clk);
      `CHK({scan_port_en_r, pin_out_en_r, pin_pullup_r, pin_in_en_r, logic_en_r}, 5'h14)
      // Without programming mode every operation is refused, random ones too, with an idle cycle between requests
      for (int i = 0; i < 9; i++)
         req(3'(i < 5 ? i : $urandom % 8), 1'h0);
      for (int i = 0; i < 8; i++)
      begin
         ins(ic[i]);
         `CHK({instr_class_r, internal_test_mode_r}, {cc[i], i == 6})
      end
      ins(`PCLS_IR_ISP_ENTER);
      `CHK({in_system_programming_r, pin_pullup_r, pin_out_en_r}, 3'h6)
      // With the clock enable low an exit instruction must leave programming mode and the instruction class untouched
      ce = 0;
      ins(`PCLS_IR_ISP_EXIT);
      `CHK({in_system_programming_r, instr_class_r}, {1'h1, `PCLS_CL_ISP_ENTER})
      ce = 1;
      req(`PCLS_OP_READ, 1'h1);
      req(`PCLS_OP_SET_RP, 1'h1);
      req(`PCLS_OP_READ, 1'h0);
      req(`PCLS_OP_PROGRAM, 1'h0);
      req(`PCLS_OP_ERASE, 1'h1);
      req(`PCLS_OP_SET_WP, 1'h1);
      req(`PCLS_OP_ERASE, 1'h0);
      req(`PCLS_OP_PROGRAM, 1'h0);
      @(negedge clk);
      `CHK({read_prot_r, write_prot_r}, 2'h1)
      // Host side of the unlock: the two private instructions back to back
      ins(`PCLS_IR_UNLOCK_A);
      ins(`PCLS_IR_UNLOCK_B);
      `CHK(write_prot_r, 1'h0)
      req(`PCLS_OP_PROGRAM, 1'h1);
      @(negedge clk);
      `CHK(programmed_r, 1'h1)
      ins(`PCLS_IR_ISP_EXIT);
      `CHK({pin_out_en_r, pin_bus_hold_r, pin_in_en_r, logic_en_r, pin_pullup_r}, 5'h1E)
      `CHK(scan_port_en_r, 1'h1)
      core_supply_good = 0;
      repeat (6) @(negedge clk);
      `CHK({cfg_done_r, pin_out_en_r, pin_pullup_r}, 3'h1)
      // Second power-up of a programmed, read-protected array goes straight to user operation
      nv_programmed = 1;
      nv_read_prot = 1;
      core_supply_good = 1;
      t = 0;
      while (cfg_done_r !== 1'h1 && t < 200)
      begin
         @(negedge clk);
         t++;
      end
      repeat (2) @(negedge clk);
      `CHK({n, pin_out_en_r, pin_pullup_r, read_prot_r, scan_port_en_r}, {8'(NA), 4'hB})
      summarize();
   end
endmodule // pcls_loader_bench
`default_nettype wire

/* File: verification/pcls_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcls_consts.vh"
module pcls_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic req_valid,
   input wire logic [2:0] req_op,
   input wire logic latch_clear_r,
   input wire logic latch_strobe_r,
   input wire logic cfg_done_r,
   input wire logic scan_port_en_r,
   input wire logic pin_out_en_r,
   input wire logic pin_pullup_r,
   input wire logic programmed_r,
   input wire logic in_system_programming_r,
   input wire logic read_prot_r,
   input wire logic write_prot_r,
   input wire logic op_grant_r,
   input wire logic op_refuse_r,
   input wire logic [2:0] op_code_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_quiet_pullup: assert property (!cfg_done_r && !$past(cfg_done_r)
      && !$past(cfg_done_r, 2) |-> pin_pullup_r && !pin_out_en_r)
      else $error("pins active while not loaded");
   a_user_pins: assert property (pin_out_en_r |-> $past(cfg_done_r) && programmed_r)
      else $error("outputs on outside user operation");
   a_scan_after: assert property ($rose(scan_port_en_r) |-> $past(cfg_done_r))
      else $error("scan port enabled before load done");
   a_clear_first: assert property (latch_clear_r |=> !latch_strobe_r [*4])
      else $error("strobe too soon after clear");
   a_strobe_gap: assert property (latch_strobe_r |=> !latch_strobe_r [*4])
      else $error("strobes too close");
   a_one_answer: assert property (req_valid && ce && cfg_done_r
      |=> op_grant_r != op_refuse_r) else $error("request not answered once");
   a_read_locked: assert property (req_valid && ce && cfg_done_r && read_prot_r
      && req_op == `PCLS_OP_READ |=> op_refuse_r) else $error("protected read granted");
   a_prog_locked: assert property (req_valid && ce && cfg_done_r
      && (read_prot_r || write_prot_r) && req_op == `PCLS_OP_PROGRAM |=> op_refuse_r)
      else $error("locked program granted");
   a_erase_locked: assert property (req_valid && ce && cfg_done_r && write_prot_r
      && req_op == `PCLS_OP_ERASE |=> op_refuse_r) else $error("locked erase granted");
   a_erase_clears: assert property (op_grant_r && op_code_r == `PCLS_OP_ERASE
      |-> !read_prot_r && !write_prot_r && !programmed_r) else $error("erase kept state");
   a_isp_float: assert property (in_system_programming_r && $past(in_system_programming_r)
      |-> pin_pullup_r && !pin_out_en_r) else $error("pins driven while programming");
endmodule // pcls_checker
bind pcls_loader pcls_checker u_chk (.clk, .rst_n, .ce, .req_valid, .req_op, .latch_clear_r,
   .latch_strobe_r, .cfg_done_r, .scan_port_en_r, .pin_out_en_r, .pin_pullup_r, .programmed_r,
   .in_system_programming_r, .read_prot_r, .write_prot_r, .op_grant_r, .op_refuse_r, .op_code_r);
`default_nettype wire

/* File: verification/pcls_nv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcls_nv_model (
   input wire logic clk,
   input wire logic [7:0] nv_addr,
   input wire logic nv_rd_en,
   input wire logic [31:0] key,
   output logic [31:0] nv_data
);
   logic [31:0] last_r = 32'h0;
   // Word is a keyed copy of its address; an idle array shows the inverse of its last word
   assign nv_data = nv_rd_en ? key ^ {4{nv_addr}} : ~last_r;
   always @(posedge clk) last_r <= nv_data;
endmodule // pcls_nv_model
`default_nettype wire
